// ---- common/substring_defs.svh ----
// constants for the substring extract and overwrite engine
`ifndef SUBSTRING_DEFS_SVH
`define SUBSTRING_DEFS_SVH

`define SUBSTR_WORD_W      16
`define SUBSTR_ERROR_CODE  16'h1A32
`define SUBSTR_NULL_BYTE   8'h00
`define SUBSTR_NULL_WORD   16'h0000
`define SUBSTR_COUNT_ALL   16'hFFFF
`define SUBSTR_COUNT_NONE  16'h0000
`define SUBSTR_COUNT_LOW   16'hFFFE
`define SUBSTR_RESET_WORD  16'h0000

`endif

// ---- common/substring_pkg.sv ----
// types shared by the substring engine and its string length scanner
package substring_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_POS,
        ST_CNT,
        ST_CHECK,
        ST_SCAN_SRC,
        ST_SCAN_DST,
        ST_PLAN,
        ST_RD_SRC,
        ST_RD_DST,
        ST_NEXT,
        ST_TERM,
        ST_ERROR,
        ST_DONE
    } state_type;

    typedef enum logic [1:0] {
        SC_IDLE,
        SC_REQ,
        SC_WAIT
    } scan_state_type;

endpackage

// ---- verilog/string_length_scan.sv ----
// walks a word range and reports the byte length up to the first zero byte
`timescale 1ns/1ps
`include "substring_defs.svh"

module string_length_scan
    import substring_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              start,
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic [ADDR_W-1:0] limit,
    input  wire logic              rvalid,
    input  wire logic [15:0]       rdata,
    output logic                   req,
    output logic [ADDR_W-1:0]      addr,
    output logic                   done,
    output logic                   found,
    output logic [15:0]            length
);

    scan_state_type    state_q;
    logic [ADDR_W-1:0] limit_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= SC_IDLE;
            addr    <= '0;
            limit_q <= '0;
            length  <= `SUBSTR_RESET_WORD;
            req     <= 1'b0;
            done    <= 1'b0;
            found   <= 1'b0;
        end else begin
            req  <= 1'b0;
            done <= 1'b0;
            unique case (state_q)
                SC_IDLE: begin
                    if (start) begin
                        addr    <= base;
                        limit_q <= limit;
                        length  <= `SUBSTR_RESET_WORD;
                        state_q <= SC_REQ;
                    end
                end
                SC_REQ: begin
                    req     <= 1'b1;
                    state_q <= SC_WAIT;
                end
                SC_WAIT: begin
                    if (rvalid) begin
                        // low byte holds the earlier character of the pair
                        if (rdata[7:0] == `SUBSTR_NULL_BYTE) begin
                            found   <= 1'b1;
                            done    <= 1'b1;
                            state_q <= SC_IDLE;
                        end else if (rdata[15:8] == `SUBSTR_NULL_BYTE) begin
                            length  <= length + 16'h0001;
                            found   <= 1'b1;
                            done    <= 1'b1;
                            state_q <= SC_IDLE;
                        end else if (addr == limit_q) begin
                            found   <= 1'b0;
                            done    <= 1'b1;
                            state_q <= SC_IDLE;
                        end else begin
                            addr    <= addr + ADDR_W'(1);
                            length  <= length + 16'h0002;
                            state_q <= SC_REQ;
                        end
                    end
                end
            endcase
        end
    end

endmodule // string_length_scan

// ---- verilog/substring_extract_overwrite.sv ----
// substring extract and overwrite engine on a word-wide device memory
`timescale 1ns/1ps
`include "substring_defs.svh"

module substring_extract_overwrite
    import substring_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              command_input,
    input  wire logic              pulsed_mode,
    input  wire logic              overwrite_select,
    input  wire logic              error_clear,
    input  wire logic [ADDR_W-1:0] source_string_operand,
    input  wire logic [ADDR_W-1:0] source_limit,
    input  wire logic [ADDR_W-1:0] position_count_operand,
    input  wire logic [ADDR_W-1:0] dest_operand,
    input  wire logic [ADDR_W-1:0] dest_limit,
    input  wire logic [15:0]       mem_rdata,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic                   mem_rd,
    output logic                   mem_wr,
    output logic [15:0]            mem_wdata,
    output logic                   busy,
    output logic                   done,
    output logic                   operation_error_flag,
    output logic [15:0]            error_code_word
);

    state_type          state_q;
    logic               cmd_prev_q;
    logic               edge_pend_q;
    logic               ovw_q;
    logic [ADDR_W-1:0]  src_q;
    logic [ADDR_W-1:0]  srclim_q;
    logic [ADDR_W-1:0]  pcop_q;
    logic [ADDR_W-1:0]  dst_q;
    logic [ADDR_W-1:0]  dstlim_q;
    logic signed [15:0] pos_q;
    logic signed [15:0] cnt_q;
    logic [15:0]        src_len_q;
    logic [15:0]        dst_len_q;
    logic [15:0]        s_q;
    logic [15:0]        n_q;
    logic [15:0]        i_q;
    logic [7:0]         acc_q;
    logic [7:0]         byte_q;
    logic               pend_q;
    logic               rvalid_q;

    logic               start_go;
    logic               rd_go;
    logic               wr_go;
    logic [ADDR_W-1:0]  rd_addr;
    logic [ADDR_W-1:0]  wr_addr;
    logic [15:0]        wr_data;
    logic [15:0]        bidx;
    logic [7:0]         sbyte;
    logic               scan_start;
    logic [ADDR_W-1:0]  scan_base;
    logic [ADDR_W-1:0]  scan_limit;
    logic               scan_req;
    logic [ADDR_W-1:0]  scan_addr;
    logic               scan_done;
    logic               scan_found;
    logic [15:0]        scan_len;
    logic [15:0]        s_pos;
    logic [15:0]        s_sel;
    logic [15:0]        n_sel;
    logic [15:0]        room;
    logic [16:0]        dst_words;
    logic               ext_err;
    logic               ovw_err;

    // a pulsed request that lands while busy is held, not dropped
    assign start_go = (state_q == ST_IDLE)
                   && (pulsed_mode ? edge_pend_q : command_input);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_prev_q  <= 1'b0;
            edge_pend_q <= 1'b0;
        end else begin
            cmd_prev_q <= command_input;
            if (command_input && !cmd_prev_q) begin
                edge_pend_q <= 1'b1;
            end else if (start_go && pulsed_mode) begin
                edge_pend_q <= 1'b0;
            end
        end
    end

    // byte index into the source or destination; one count per byte
    assign bidx  = s_q + i_q;
    assign sbyte = bidx[0] ? mem_rdata[15:8] : mem_rdata[7:0];

    // position 0 and 1 both name the first character
    assign s_pos = (pos_q == 16'sh0000) ? 16'h0000 : 16'(pos_q - 16'sh0001);
    assign s_sel = (!ovw_q && cnt_q == `SUBSTR_COUNT_ALL) ? 16'h0000 : s_pos;
    assign n_sel = (cnt_q == `SUBSTR_COUNT_ALL) ? src_len_q : cnt_q;
    assign dst_words = 17'(dstlim_q - dst_q) + 17'h00001;
    assign room = dst_len_q - s_sel;

    assign ext_err = (17'(s_sel) + 17'(n_sel) > 17'(src_len_q))
                  || ({2'b00, n_sel} > {dst_words, 1'b0})
                  || (17'(n_sel[15:1]) + 17'h00001 > dst_words);
    assign ovw_err = (16'(pos_q) > dst_len_q)
                  || (cnt_q != `SUBSTR_COUNT_ALL && n_sel > src_len_q);

    assign scan_start = (state_q == ST_CHECK && !(pos_q < 16'sh0000)
                         && !(cnt_q <= $signed(`SUBSTR_COUNT_LOW))
                         && cnt_q != `SUBSTR_COUNT_NONE)
                     || (state_q == ST_SCAN_SRC && scan_done && scan_found && ovw_q);
    assign scan_base  = (state_q == ST_CHECK) ? src_q : dst_q;
    assign scan_limit = (state_q == ST_CHECK) ? srclim_q : dstlim_q;

    string_length_scan #(
        .ADDR_W (ADDR_W)
    ) u_scan (
        .clk    (clk),
        .reset  (reset),
        .start  (scan_start),
        .base   (scan_base),
        .limit  (scan_limit),
        .rvalid (rvalid_q),
        .rdata  (mem_rdata),
        .req    (scan_req),
        .addr   (scan_addr),
        .done   (scan_done),
        .found  (scan_found),
        .length (scan_len)
    );

    always_comb begin
        rd_go   = 1'b0;
        rd_addr = '0;
        wr_go   = 1'b0;
        wr_addr = '0;
        wr_data = `SUBSTR_NULL_WORD;
        unique case (state_q)
            ST_POS: begin
                rd_go   = !pend_q;
                rd_addr = pcop_q;
            end
            ST_CNT: begin
                rd_go   = !pend_q;
                rd_addr = pcop_q + ADDR_W'(1);
            end
            ST_SCAN_SRC, ST_SCAN_DST: begin
                rd_go   = scan_req;
                rd_addr = scan_addr;
            end
            ST_RD_SRC: begin
                rd_go   = !pend_q;
                // overwrite takes the source from its head, not from the start offset
                rd_addr = src_q + ADDR_W'(ovw_q ? i_q[15:1] : bidx[15:1]);
                if (rvalid_q && !ovw_q && i_q[0]) begin
                    wr_go   = 1'b1;
                    wr_addr = dst_q + ADDR_W'(i_q[15:1]);
                    wr_data = {sbyte, acc_q};
                end
            end
            ST_RD_DST: begin
                rd_go   = !pend_q;
                rd_addr = dst_q + ADDR_W'(bidx[15:1]);
                if (rvalid_q) begin
                    wr_go   = 1'b1;
                    wr_addr = rd_addr;
                    wr_data = bidx[0] ? {byte_q, mem_rdata[7:0]}
                                      : {mem_rdata[15:8], byte_q};
                end
            end
            ST_TERM: begin
                wr_go   = 1'b1;
                wr_addr = dst_q + ADDR_W'(n_q[15:1]);
                wr_data = n_q[0] ? {`SUBSTR_NULL_BYTE, acc_q}
                                 : `SUBSTR_NULL_WORD;
            end
            default: begin
                rd_go = 1'b0;
            end
        endcase
    end

    // memory port; read data is valid the cycle after mem_rd
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_addr  <= '0;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wdata <= `SUBSTR_NULL_WORD;
            rvalid_q  <= 1'b0;
            pend_q    <= 1'b0;
        end else begin
            mem_rd   <= rd_go;
            mem_wr   <= wr_go;
            rvalid_q <= mem_rd;
            if (wr_go) begin
                mem_addr  <= wr_addr;
                mem_wdata <= wr_data;
            end else if (rd_go) begin
                mem_addr <= rd_addr;
            end
            if (rvalid_q) begin
                pend_q <= 1'b0;
            end else if (rd_go && state_q != ST_SCAN_SRC && state_q != ST_SCAN_DST) begin
                pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            ovw_q     <= 1'b0;
            src_q     <= '0;
            srclim_q  <= '0;
            pcop_q    <= '0;
            dst_q     <= '0;
            dstlim_q  <= '0;
            pos_q     <= 16'sh0000;
            cnt_q     <= 16'sh0000;
            src_len_q <= `SUBSTR_RESET_WORD;
            dst_len_q <= `SUBSTR_RESET_WORD;
            s_q       <= `SUBSTR_RESET_WORD;
            n_q       <= `SUBSTR_RESET_WORD;
            i_q       <= `SUBSTR_RESET_WORD;
            acc_q     <= `SUBSTR_NULL_BYTE;
            byte_q    <= `SUBSTR_NULL_BYTE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (start_go) begin
                        ovw_q    <= overwrite_select;
                        src_q    <= source_string_operand;
                        srclim_q <= source_limit;
                        pcop_q   <= position_count_operand;
                        dst_q    <= dest_operand;
                        dstlim_q <= dest_limit;
                        state_q  <= ST_POS;
                    end
                end
                ST_POS: begin
                    if (rvalid_q) begin
                        pos_q   <= mem_rdata;
                        state_q <= ST_CNT;
                    end
                end
                ST_CNT: begin
                    if (rvalid_q) begin
                        cnt_q   <= mem_rdata;
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (pos_q < 16'sh0000 || cnt_q <= $signed(`SUBSTR_COUNT_LOW)) begin
                        state_q <= ST_ERROR;
                    end else if (cnt_q == `SUBSTR_COUNT_NONE) begin
                        state_q <= ST_DONE;
                    end else begin
                        state_q <= ST_SCAN_SRC;
                    end
                end
                ST_SCAN_SRC: begin
                    if (scan_done) begin
                        src_len_q <= scan_len;
                        if (!scan_found) begin
                            state_q <= ST_ERROR;
                        end else if (ovw_q) begin
                            state_q <= ST_SCAN_DST;
                        end else begin
                            state_q <= ST_PLAN;
                        end
                    end
                end
                ST_SCAN_DST: begin
                    if (scan_done) begin
                        dst_len_q <= scan_len;
                        state_q   <= scan_found ? ST_PLAN : ST_ERROR;
                    end
                end
                ST_PLAN: begin
                    s_q <= s_sel;
                    i_q <= `SUBSTR_RESET_WORD;
                    if (!ovw_q) begin
                        n_q <= n_sel;
                        if (ext_err) begin
                            state_q <= ST_ERROR;
                        end else begin
                            state_q <= (n_sel == 16'h0000) ? ST_TERM : ST_RD_SRC;
                        end
                    end else begin
                        // past the last character nothing is written
                        n_q <= (n_sel > room) ? room : n_sel;
                        if (ovw_err) begin
                            state_q <= ST_ERROR;
                        end else begin
                            state_q <= (n_sel == 16'h0000 || room == 16'h0000)
                                       ? ST_DONE : ST_RD_SRC;
                        end
                    end
                end
                ST_RD_SRC: begin
                    if (rvalid_q) begin
                        if (ovw_q) begin
                            // source is read from its head; s_q aims the destination
                            byte_q  <= i_q[0] ? mem_rdata[15:8] : mem_rdata[7:0];
                            state_q <= ST_RD_DST;
                        end else begin
                            if (!i_q[0]) begin
                                acc_q <= sbyte;
                            end
                            state_q <= ST_NEXT;
                        end
                    end
                end
                ST_RD_DST: begin
                    if (rvalid_q) begin
                        state_q <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    i_q <= i_q + 16'h0001;
                    if (i_q + 16'h0001 == n_q) begin
                        state_q <= ovw_q ? ST_DONE : ST_TERM;
                    end else begin
                        state_q <= ST_RD_SRC;
                    end
                end
                ST_TERM: begin
                    state_q <= ST_DONE;
                end
                ST_ERROR: begin
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy                 <= 1'b0;
            done                 <= 1'b0;
            operation_error_flag <= 1'b0;
            error_code_word      <= `SUBSTR_RESET_WORD;
        end else begin
            busy <= start_go || (state_q != ST_IDLE && state_q != ST_DONE);
            done <= (state_q == ST_DONE);
            // a new error in the clearing cycle still wins
            if (state_q == ST_ERROR) begin
                operation_error_flag <= 1'b1;
                error_code_word      <= `SUBSTR_ERROR_CODE;
            end else if (error_clear) begin
                operation_error_flag <= 1'b0;
                error_code_word      <= `SUBSTR_RESET_WORD;
            end
        end
    end

endmodule // substring_extract_overwrite

// ---- testbench/word_memory.sv ----
// one-cycle word memory standing in for the sequencer's device range
`timescale 1ns/1ps

module word_memory #(
    parameter int ADDR_W = 16
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_rd,
    input  wire logic              mem_wr,
    input  wire logic [15:0]       mem_wdata,
    output logic [15:0]            mem_rdata
);
    logic [15:0] ram [0:255];

    initial mem_rdata = 16'h0000;

    // outside a read answer the data toggles, so a stale sample cannot pass
    always @(posedge clk) begin
        if (mem_rd) begin
            mem_rdata <= ram[mem_addr[7:0]];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_wr) begin
            ram[mem_addr[7:0]] <= mem_wdata;
        end
    end
endmodule // word_memory

// ---- testbench/substring_extract_overwrite_properties.sv ----
// port checker for the substring engine
`timescale 1ns/1ps
`include "substring_defs.svh"

module substring_extract_overwrite_properties #(
    parameter int ADDR_W = 16
) (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              command_input,
    input wire logic              pulsed_mode,
    input wire logic              error_clear,
    input wire logic [ADDR_W-1:0] dest_operand,
    input wire logic [ADDR_W-1:0] dest_limit,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic              mem_rd,
    input wire logic              mem_wr,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              operation_error_flag,
    input wire logic [15:0]       error_code_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    sequence bus_access; mem_rd || mem_wr; endsequence
    sequence quiet_bus; !mem_rd && !mem_wr; endsequence

    rd_wr_excl_a: assert property (!(mem_rd && mem_wr))
        else $error("read and write in one cycle");
    access_gap_a: assert property (bus_access |=> quiet_bus)
        else $error("memory accesses too close");
    access_busy_a: assert property (bus_access |-> busy)
        else $error("memory access while idle");
    done_single_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    code_on_error_a: assert property (operation_error_flag |-> error_code_word == `SUBSTR_ERROR_CODE)
        else $error("error flag without error code");
    code_cleared_a: assert property (!operation_error_flag |-> error_code_word == `SUBSTR_RESET_WORD)
        else $error("error code without error flag");
    flag_sticky_a: assert property ($fell(operation_error_flag) |-> $past(error_clear))
        else $error("error flag dropped without clear");
    flag_cause_a: assert property ($rose(operation_error_flag) |-> $past(busy))
        else $error("error flag set outside an operation");
    write_range_a: assert property (mem_wr |-> mem_addr >= dest_operand && mem_addr <= dest_limit)
        else $error("write outside destination range");
    pulse_start_a: assert property ($rose(command_input) && pulsed_mode && !busy |-> ##[1:2] busy)
        else $error("pulsed request not started");
endmodule // substring_extract_overwrite_properties

bind substring_extract_overwrite substring_extract_overwrite_properties #(.ADDR_W(ADDR_W)) i_props (
    .clk(clk), .reset(reset), .command_input(command_input), .pulsed_mode(pulsed_mode),
    .error_clear(error_clear), .dest_operand(dest_operand), .dest_limit(dest_limit),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .busy(busy), .done(done),
    .operation_error_flag(operation_error_flag), .error_code_word(error_code_word));

// ---- testbench/tb.sv ----
// self-checking bench for the substring engine
`timescale 1ns/1ps

module tb;
    import substring_pkg::*;
    logic        clk = 0, reset = 1, command_input = 0, pulsed_mode = 1;
    logic        overwrite_select = 0, error_clear = 0, mem_rd, mem_wr, busy, done, flag;
    logic [15:0] src = 0, slim = 16'h00FF, pcop = 16'h0008, dst = 16'h0040, dlim = 16'h004F;
    logic [15:0] mem_rdata, mem_addr, mem_wdata, code;
    int          errors = 0, check_count = 0, n;

    always #50 clk = ~clk;

    substring_extract_overwrite #(.ADDR_W(16)) i_substring_extract_overwrite (
        .clk(clk), .reset(reset), .command_input(command_input), .pulsed_mode(pulsed_mode),
        .overwrite_select(overwrite_select), .error_clear(error_clear),
        .source_string_operand(src), .source_limit(slim), .position_count_operand(pcop),
        .dest_operand(dst), .dest_limit(dlim), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .busy(busy), .done(done),
        .operation_error_flag(flag), .error_code_word(code));
    word_memory #(.ADDR_W(16)) i_word_memory (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic complete_run;
        if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // low byte first, then the zero terminator word or byte
    function automatic logic [15:0] pk(string s, int i);
        logic [7:0] lo, hi;
        lo = (2 * i < s.len()) ? s[2 * i] : 8'h00;
        hi = (2 * i + 1 < s.len()) ? s[2 * i + 1] : 8'h00;
        return {hi, lo};
    endfunction

    task automatic put_str(input int a, input string s);
        for (int i = 0; i <= s.len() / 2; i++) i_word_memory.ram[a + i] = pk(s, i);
    endtask

    task automatic check_str(input int a, input string s);
        for (int i = 0; i <= s.len() / 2; i++) chk(i_word_memory.ram[a + i], pk(s, i));
    endtask

    task automatic run(input logic ow, input logic [15:0] s, input logic [15:0] pos,
                       input logic [15:0] cnt, input logic [15:0] sl, input logic [15:0] dl);
        i_word_memory.ram[8] = pos;
        i_word_memory.ram[9] = cnt;
        @(posedge clk);
        overwrite_select <= ow;
        src <= s;
        slim <= sl;
        dlim <= dl;
        command_input <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            errors++;
            complete_run();
        end
        chk({15'h0, busy}, 16'h0000);
        @(posedge clk);
        command_input <= 1'b0;
    endtask

    task automatic t_extract;
        string       e [3] = '{"CDEF", "ABC", "ABCDEF"};
        logic [15:0] p [3] = '{16'h0003, 16'h0001, 16'h0004};
        logic [15:0] c [3] = '{16'h0004, 16'h0003, 16'hFFFF};
        put_str(16'h10, "ABCDEF");
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 16; i++) i_word_memory.ram[16'h40 + i] = 16'hA5A5;
            run(0, 16'h10, p[k], c[k], 16'h00FF, 16'h004F);
            check_str(16'h40, e[k]);
            chk({15'h0, flag}, 16'h0000);
        end
        for (int i = 0; i < 16; i++) i_word_memory.ram[16'h40 + i] = 16'hA5A5;
        run(0, 16'h10, 16'h0001, 16'h0000, 16'h00FF, 16'h004F);
        chk(i_word_memory.ram[16'h40], 16'hA5A5);
    endtask

    task automatic t_overwrite;
        string       e [4] = '{"aXYdef", "abcdXY", "abcdef", "XYZdef"};
        logic [15:0] p [4] = '{16'h0002, 16'h0005, 16'h0001, 16'h0001};
        logic [15:0] c [4] = '{16'h0002, 16'hFFFF, 16'h0000, 16'h0003};
        put_str(16'h20, "XYZ");
        for (int k = 0; k < 4; k++) begin
            put_str(16'h40, "abcdef");
            run(1, 16'h20, p[k], c[k], 16'h00FF, 16'h004F);
            check_str(16'h40, e[k]);
        end
    endtask

    task automatic t_errors;
        logic        o [7] = '{0, 1, 0, 0, 0, 1, 1};
        logic [15:0] p [7] = '{16'hFFFF, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0008, 16'h0001};
        logic [15:0] c [7] = '{16'h0001, 16'hFFFE, 16'h0002, 16'h0006, 16'h0006, 16'h0001, 16'h0004};
        logic [15:0] l [7] = '{16'h00FF, 16'h00FF, 16'h0012, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};
        logic [15:0] d [7] = '{16'h004F, 16'h004F, 16'h004F, 16'h0041, 16'h0042, 16'h004F, 16'h004F};
        for (int k = 0; k < 7; k++) begin
            put_str(16'h40, "abcdef");
            run(o[k], o[k] ? 16'h20 : 16'h10, p[k], c[k], l[k], d[k]);
            chk({15'h0, flag}, 16'h0001);
            chk(code, 16'h1A32);
            error_clear <= 1'b1;
            @(posedge clk);
            error_clear <= 1'b0;
            @(negedge clk);
            chk({15'h0, flag}, 16'h0000);
            chk(code, 16'h0000);
        end
    endtask

    // held command: once in pulsed mode, repeatedly in continuous mode
    task automatic t_modes;
        int k [2];
        i_word_memory.ram[9] = 16'h0000;
        for (int m = 0; m < 2; m++) begin
            k[m] = 0;
            @(posedge clk);
            pulsed_mode <= (m == 0);
            command_input <= 1'b1;
            repeat (200) begin
                @(negedge clk);
                if (done === 1'b1) k[m]++;
            end
            @(posedge clk);
            command_input <= 1'b0;
            repeat (50) @(posedge clk);
        end
        pulsed_mode <= 1'b1;
        chk(16'(k[0]), 16'h0001);
        chk(16'(k[1] > 2), 16'h0001);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        t_extract();
        t_overwrite();
        t_errors();
        t_modes();
        complete_run();
    end
endmodule // tb
